// ### dv/coil_sense_model.sv
`timescale 1ns/1ns
// --------
// coil current sense stand-in
// --------
module coil_sense_model #(
  parameter int LAG  = 4,
  parameter int IDLE = 1200
) (
  input  wire logic        clk_in,
  input  wire logic        leg_a_in,
  input  wire logic        leg_b_in,
  input  wire logic [11:0] level_in,
  output logic      [11:0] amp_out = 12'h000
);
  int idle_cnt = IDLE;
  int run_cnt  = 0;

  // current flows while the bridge switches and for IDLE cycles after it stops, following a settling lag
  always @(posedge clk_in) begin
    idle_cnt <= (leg_a_in || leg_b_in) ? 0 : (idle_cnt < IDLE ? idle_cnt + 1 : IDLE);
    run_cnt  <= (idle_cnt < IDLE) ? (run_cnt < LAG ? run_cnt + 1 : LAG) : 0;
    amp_out  <= (run_cnt >= LAG) ? level_in : 12'h000;
  end
endmodule : coil_sense_model

// ### dv/tb.sv
`timescale 1ns/1ns
`include "power_drive_map.svh"
// --------
// drive core bench
// --------
module tb;
  localparam int STEP  = 40;
  localparam int LIMIT = 40000;
  logic        clk = 1'b0, srst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, a_q = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [11:0] level = 12'h000, amp;
  logic [1:0]  rsp, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, leg_a, leg_b;
  int          n_fail = 0, num_checks = 0, cyc = 0, hi;
  int          a_rise = 0, a_per = 0, a_high = 0;

  inductive_power_drive_pid #(.STEP_CYCLES(STEP), .CNT_W(20)) u_dut (
    .CLK_IN(clk), .SRST_IN(srst),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .COIL_AMP_IN(amp), .BRIDGE_A_OUT(leg_a), .BRIDGE_B_OUT(leg_b)
  );

  coil_sense_model u_coil (
    .clk_in(clk), .leg_a_in(leg_a), .leg_b_in(leg_b), .level_in(level), .amp_out(amp)
  );

  // clock
  always #5 clk = ~clk;

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(nm, e, d);
  endtask : rd_chk

  function automatic int band_step(int f);
    return f < 280000 ? 3 : f < 320000 ? 4 : f < 360000 ? 6 : 10;
  endfunction : band_step

  // wait for one loop step and compare the new frequency with the output
  task automatic step_check();
    logic [31:0] f0, f1, p;
    int e;
    rd(`REG_FREQ, f0);
    do rd(`REG_FREQ, f1); while (f1 === f0);
    rd(`REG_PID, p);
    e = int'(f0) - band_step(int'(f0)) * $signed(p);
    e = e < 220000 ? 220000 : (e > 410000 ? 410000 : e);
    check("freq_step", 32'(e), f1);
  endtask : step_check

  // hang guard and leg watch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      finish_test();
    end
    if (!srst) check("leg_overlap", 32'h0, {31'h0, leg_a & leg_b});
    if (leg_a && !a_q) begin
      a_per <= cyc - a_rise;
      a_rise <= cyc;
    end
    if (!leg_a && a_q) a_high <= cyc - a_rise;
    a_q <= leg_a;
  end

  // --------
  // main sequence
  // --------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd_chk("freq_rst", `REG_FREQ, 32'h00055730);
    rd_chk("duty_rst", `REG_DUTY, 32'h00001388);
    rd_chk("status_rst", `REG_STATUS, 32'h0);
    wr(`REG_TARGET, 32'h1234, 4'hF);
    wr(`REG_TARGET, 32'hFFFF, 4'h1);
    rd_chk("target_strb", `REG_TARGET, 32'h12FF);
    wr(`REG_FREQ, 32'h0, 4'hF);
    check("ro_resp", `RESP_OKAY, rsp);
    rd_chk("ro_keep", `REG_FREQ, 32'h00055730);
    wr(8'h1C, 32'h1, 4'hF);
    check("wr_unmap", `RESP_SLVERR, rsp);
    rd_chk("rd_unmap", 8'h1C, 32'h0);
    check("rd_unmap_rsp", `RESP_SLVERR, rsp);
    wr(`REG_TARGET, 32'h0, 4'hF);
    wr(`REG_CTRL, 32'h1, 4'hF);
    repeat (1800) @(posedge clk);
    rd_chk("ping_freq", `REG_FREQ, 32'h00055730);
    rd_chk("ping_duty", `REG_DUTY, 32'h00001388);
    check("ping_per", 32'h1, 32'(a_per >= 570 && a_per <= 573));
    check("ping_high", 32'h1, 32'(a_high >= 285 && a_high <= 287));
    level <= 12'h3E8;
    wr(`REG_TARGET, 32'h384, 4'hF);
    repeat (5) step_check();
    repeat (2000) @(posedge clk);
    rd_chk("freq_ceil", `REG_FREQ, 32'h00064190);
    rd_chk("duty_hold", `REG_DUTY, 32'h00001388);
    check("ceil_per", 32'h1, 32'(a_per >= 487 && a_per <= 489));
    wr(`REG_CTRL, 32'h3, 4'hF);
    repeat (2000) @(posedge clk);
    rd_chk("duty_floor", `REG_DUTY, 32'h000003E8);
    rd_chk("status_duty", `REG_STATUS, 32'h7);
    check("floor_high", 32'h1, 32'(a_high >= 48 && a_high <= 49));
    // leg b over two ceiling periods at ten percent duty
    hi = 0;
    repeat (976) @(posedge clk) hi += int'(leg_b);
    check("floor_b_high", 32'h1, 32'(hi >= 95 && hi <= 99));
    wr(`REG_CTRL, 32'h0, 4'hF);
    repeat (4) @(posedge clk);
    hi = 0;
    repeat (600) @(posedge clk) hi += int'(leg_a | leg_b);
    check("legs_off", 32'h0, 32'(hi));
    rd_chk("status_off", `REG_STATUS, 32'h4);
    rd_chk("freq_kept", `REG_FREQ, 32'h00064190);
    wr(`REG_TARGET, 32'h514, 4'hF);
    wr(`REG_CTRL, 32'h1, 4'hF);
    repeat (2) @(posedge clk);
    repeat (8) step_check();
    repeat (3000) @(posedge clk);
    rd_chk("freq_floor", `REG_FREQ, 32'h00035B60);
    wr(`REG_TARGET, 32'hFA0, 4'hF);
    repeat (1200) @(posedge clk);
    rd_chk("pid_max", `REG_PID, 32'h00004E20);
    wr(`REG_TARGET, 32'h3F2, 4'hF);
    repeat (120) @(posedge clk);
    rd_chk("pid_int", `REG_PID, 32'h00000C1C);
    level <= 12'hFA0;
    wr(`REG_TARGET, 32'h0, 4'hF);
    repeat (200) @(posedge clk);
    rd_chk("pid_min", `REG_PID, 32'hFFFFB1E0);
    finish_test();
  end
endmodule : tb

// ### hw/bridge_nco.sv
`timescale 1ns/1ns
`include "power_drive_map.svh"
module bridge_nco (
  input wire logic clk_in,
  input wire logic srst_in,
  bridge_if.gen    drv
);
  logic [31:0] phase_reg;
  logic [31:0] phase_next;
  logic        leg_a_reg;
  logic        leg_a_next;
  logic        leg_b_reg;
  logic        leg_b_next;
  logic [39:0] inc_prod;
  logic [32:0] thr_prod;
  logic [31:0] inc;
  logic [31:0] thr;
  logic [31:0] half;

  // ----------------------------------------
  // phase accumulator and leg compare
  // ----------------------------------------
  always_comb begin
    inc_prod   = 40'(drv.freq) * 40'(`NCO_INC_MUL); // see [RQ4] see [RQ5]
    thr_prod   = 33'(drv.duty) * 33'(`DUTY_THR_MUL); // see [RQ6]
    inc        = {8'h00, inc_prod[39:16]};
    thr        = thr_prod[31:0];
    half       = phase_reg - `PHASE_HALF;
    phase_next = drv.run ? phase_reg + inc : 32'h00000000;
    leg_a_next = drv.run && (phase_reg < thr); // see [RQ1]
    leg_b_next = drv.run && (half < thr); // see [RQ2]
  end

  // register stage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_reg <= 32'h00000000;
      leg_a_reg <= 1'b0;
      leg_b_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      leg_a_reg <= leg_a_next;
      leg_b_reg <= leg_b_next;
    end
  end

  assign drv.leg_a = leg_a_reg;
  assign drv.leg_b = leg_b_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  chk_legs_apart: assert property (!(leg_a_reg && leg_b_reg)) // see [RQ1]
    else $error("both bridge legs high");
  chk_legs_idle: assert property (!drv.run |=> !leg_a_reg && !leg_b_reg) // see [RQ14]
    else $error("bridge driven while stopped");
endmodule : bridge_nco

// ### hw/inductive_power_drive_pid.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "power_drive_map.svh"
// Operation
// [RQ1] drive 110 to 205 kHz at 50 percent
// [RQ2] reduce duty 10-50 percent only at 205 kHz
// [RQ3] higher frequency or lower duty means less power
// [RQ4] frequency step fine enough, 110-175 kHz band
// [RQ5] frequency step fine enough, 175-205 kHz band
// [RQ6] duty step 0.1 percent or finer
// [RQ7] ping starts at 175 kHz, 50 percent
// [RQ8] loop controls frequency or duty
// [RQ9] coil current resolved to 7 mA or finer
// [RQ10] gains 10, 0.05, 0; limits 3000, 20000
// [RQ11] duty control: same loop, -0.01 percent scale
// [RQ12] frequency scale 1.5, 2, 3, 5 Hz by band
// [RQ13] clamp integral, clamp output, add to variable
// [RQ14] saturate frequency and duty at range edges
module inductive_power_drive_pid #(
  parameter int unsigned STEP_CYCLES = `STEP_US * `CLK_MHZ,
  parameter int unsigned CNT_W       = 20
) (
  input  wire logic        CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic [7:0]  AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [7:0]  ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  input  wire logic [11:0] COIL_AMP_IN,
  output logic             BRIDGE_A_OUT,
  output logic             BRIDGE_B_OUT
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [11:0]                     amp_meta_reg;
  logic [11:0]                     amp_sync_reg;
  logic                            aw_full_reg, aw_full_next;
  logic [7:0]                      aw_addr_reg, aw_addr_next;
  logic                            w_full_reg, w_full_next;
  logic [31:0]                     w_data_reg, w_data_next;
  logic [3:0]                      w_strb_reg, w_strb_next;
  logic                            awready_reg, awready_next;
  logic                            wready_reg, wready_next;
  logic                            bvalid_reg, bvalid_next;
  logic [1:0]                      bresp_reg, bresp_next;
  logic                            arready_reg, arready_next;
  logic                            rvalid_reg, rvalid_next;
  logic [31:0]                     rdata_reg, rdata_next;
  logic [1:0]                      rresp_reg, rresp_next;
  logic [31:0]                     ctrl_reg, ctrl_next;
  logic [31:0]                     target_reg, target_next;
  power_drive_pkg::drive_state_type state_reg, state_next;
  logic [CNT_W-1:0]                cnt_reg, cnt_next;
  power_drive_pkg::freq_type       freq_reg, freq_next;
  power_drive_pkg::duty_type       duty_reg, duty_next;
  logic signed [19:0]              isc_reg, isc_next;
  logic signed [15:0]              pid_reg, pid_next;
  logic signed [16:0]              err;
  logic signed [19:0]              isc_new;
  logic signed [33:0]              i_prod;
  logic signed [15:0]              i_term;
  logic signed [23:0]              p_term;
  logic signed [15:0]              pid_new;
  logic [3:0]                      scale_half;
  logic signed [23:0]              f_delta;
  logic signed [23:0]              f_new;
  logic signed [23:0]              d_new;
  logic                            duty_ctl;
  logic                            step;

  bridge_if drv ();

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic signed [23:0] bound(input logic signed [23:0] x,
                                               input logic signed [23:0] lo,
                                               input logic signed [23:0] hi);
    bound = (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction : bound

  function automatic logic [3:0] band_scale(input logic [18:0] f);
    if (f < `FREQ_B140_HALF) band_scale = `SCALE_B110;
    else if (f < `FREQ_B160_HALF) band_scale = `SCALE_B140;
    else if (f < `FREQ_B180_HALF) band_scale = `SCALE_B160;
    else band_scale = `SCALE_B180;
  endfunction : band_scale

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) merge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
  endfunction : merge

  // ----------------------------------------
  // coil current synchroniser
  // ----------------------------------------
  // two stages, 1 mA per bit
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      amp_meta_reg <= 12'h000;
      amp_sync_reg <= 12'h000;
    end else begin
      amp_meta_reg <= COIL_AMP_IN;
      amp_sync_reg <= amp_meta_reg; // see [RQ9]
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  // write path takes address and data in either order
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    ctrl_next    = ctrl_reg;
    target_next  = target_reg;
    if (AWVALID_IN && awready_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = AWADDR_IN;
    end
    if (WVALID_IN && wready_reg) begin
      w_full_next = 1'b1;
      w_data_next = WDATA_IN;
      w_strb_next = WSTRB_IN;
    end
    if (bvalid_reg && BREADY_IN) bvalid_next = 1'b0;
    if (aw_full_next && w_full_next && !bvalid_next) begin
      bvalid_next  = 1'b1;
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bresp_next   = `RESP_OKAY;
      case (aw_addr_next)
        `REG_CTRL: ctrl_next = merge(ctrl_reg, w_data_next, w_strb_next) & 32'h00000003;
        `REG_TARGET: target_next = merge(target_reg, w_data_next, w_strb_next) & 32'h0000FFFF;
        `REG_STATUS, `REG_FREQ, `REG_DUTY, `REG_CURRENT, `REG_PID: ;
        default: bresp_next = `RESP_SLVERR;
      endcase
    end
    awready_next = !aw_full_next;
    wready_next  = !w_full_next;
    if (rvalid_reg && RREADY_IN) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (ARVALID_IN && arready_reg) begin
      rvalid_next  = 1'b1;
      arready_next = 1'b0;
      rresp_next   = `RESP_OKAY;
      case (ARADDR_IN)
        `REG_CTRL: rdata_next = ctrl_reg;
        `REG_TARGET: rdata_next = target_reg;
        `REG_STATUS: rdata_next = {29'h00000000, duty_reg != `DUTY_MAX, state_reg};
        `REG_FREQ: rdata_next = {13'h0000, freq_reg};
        `REG_DUTY: rdata_next = {18'h00000, duty_reg};
        `REG_CURRENT: rdata_next = {20'h00000, amp_sync_reg};
        `REG_PID: rdata_next = 32'(pid_reg);
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = `RESP_SLVERR;
        end
      endcase
    end
    // ready comes back once no read answer is pending
    if (!arready_reg && !rvalid_next) arready_next = 1'b1;
  end

  // bus registers
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= `RESP_OKAY;
      ctrl_reg    <= 32'h00000000;
      target_reg  <= 32'h00000000;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      ctrl_reg    <= ctrl_next;
      target_reg  <= target_next;
    end
  end

  // ----------------------------------------
  // control loop
  // ----------------------------------------
  // pid arithmetic, evaluated every cycle, applied on step
  always_comb begin
    step     = cnt_reg == CNT_W'(STEP_CYCLES - 1);
    err      = $signed({1'b0, target_reg[15:0]}) - $signed({5'h00, amp_sync_reg}); // see [RQ9]
    isc_new  = 20'(bound(24'(isc_reg) + 24'(err), -`INT_LIMIT, `INT_LIMIT)); // see [RQ13]
    i_prod   = isc_new * `INT_DIV_MUL; // see [RQ10]
    i_term   = $signed(i_prod[31:16]);
    p_term   = 24'(err) * `PROP_GAIN; // see [RQ10]
    pid_new  = 16'(bound(p_term + 24'(i_term), -`PID_LIMIT, `PID_LIMIT)); // see [RQ13]
    scale_half = band_scale(freq_reg); // see [RQ12]
    f_delta  = 24'(pid_new) * $signed({20'h00000, scale_half});
    f_new    = bound($signed({5'h00, freq_reg}) - f_delta, $signed({5'h00, `FREQ_MIN_HALF}),
                     $signed({5'h00, `FREQ_MAX_HALF})); // see [RQ3] see [RQ14]
    d_new    = bound($signed({10'h000, duty_reg}) + 24'(pid_new), $signed({10'h000, `DUTY_MIN}),
                     $signed({10'h000, `DUTY_MAX})); // see [RQ11] see [RQ14]
    duty_ctl = (freq_reg == `FREQ_MAX_HALF) && ((duty_reg != `DUTY_MAX) ||
               (ctrl_reg[`CTRL_DUTY_BIT] && pid_new[15])); // see [RQ2] see [RQ8]
  end

  // state machine and controlled variables
  always_comb begin
    state_next = state_reg;
    freq_next  = freq_reg;
    duty_next  = duty_reg;
    isc_next   = isc_reg;
    pid_next   = pid_reg;
    cnt_next   = (state_reg == power_drive_pkg::ST_OFF || step) ? '0 : cnt_reg + 1'b1;
    unique case (state_reg)
      power_drive_pkg::ST_OFF: begin
        if (ctrl_reg[`CTRL_EN_BIT]) begin
          state_next = power_drive_pkg::ST_PING;
          freq_next  = `FREQ_PING_HALF; // see [RQ7]
          duty_next  = `DUTY_MAX; // see [RQ7]
          isc_next   = 20'sh00000;
          pid_next   = 16'sh0000;
        end
      end
      power_drive_pkg::ST_PING: begin
        if (step) state_next = power_drive_pkg::ST_REG;
      end
      power_drive_pkg::ST_REG: begin
        if (step) begin
          isc_next = isc_new;
          pid_next = pid_new;
          if (duty_ctl) duty_next = d_new[13:0]; // see [RQ11]
          else freq_next = f_new[18:0]; // see [RQ8] see [RQ13]
        end
      end
      default: state_next = power_drive_pkg::ST_OFF;
    endcase
    if (!ctrl_reg[`CTRL_EN_BIT]) state_next = power_drive_pkg::ST_OFF;
  end

  // loop registers
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state_reg <= power_drive_pkg::ST_OFF;
      cnt_reg   <= '0;
      freq_reg  <= `FREQ_PING_HALF;
      duty_reg  <= `DUTY_MAX;
      isc_reg   <= 20'sh00000;
      pid_reg   <= 16'sh0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      freq_reg  <= freq_next;
      duty_reg  <= duty_next;
      isc_reg   <= isc_next;
      pid_reg   <= pid_next;
    end
  end

  // ----------------------------------------
  // bridge oscillator and outputs
  // ----------------------------------------
  assign drv.freq = freq_reg;
  assign drv.duty = duty_reg;
  assign drv.run  = state_reg != power_drive_pkg::ST_OFF;

  bridge_nco u_nco (
    .clk_in  (CLK_IN),
    .srst_in (SRST_IN),
    .drv     (drv.gen)
  );

  assign BRIDGE_A_OUT = drv.leg_a;
  assign BRIDGE_B_OUT = drv.leg_b;
  assign AWREADY_OUT  = awready_reg;
  assign WREADY_OUT   = wready_reg;
  assign BVALID_OUT   = bvalid_reg;
  assign BRESP_OUT    = bresp_reg;
  assign ARREADY_OUT  = arready_reg;
  assign RVALID_OUT   = rvalid_reg;
  assign RDATA_OUT    = rdata_reg;
  assign RRESP_OUT    = rresp_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  sequence enter_ping;
    state_reg == power_drive_pkg::ST_OFF ##1 state_reg == power_drive_pkg::ST_PING;
  endsequence
  sequence freq_step;
    state_reg == power_drive_pkg::ST_REG && step && !duty_ctl;
  endsequence

  chk_freq_range: assert property (freq_reg >= `FREQ_MIN_HALF && // see [RQ14]
    freq_reg <= `FREQ_MAX_HALF)
    else $error("frequency out of range");
  chk_duty_range: assert property (duty_reg >= `DUTY_MIN && duty_reg <= `DUTY_MAX) // see [RQ2]
    else $error("duty out of range");
  chk_duty_ceiling: assert property (duty_reg != `DUTY_MAX |-> // see [RQ1]
    freq_reg == `FREQ_MAX_HALF)
    else $error("reduced duty below frequency ceiling");
  chk_ping_start: assert property (enter_ping |-> // see [RQ7]
    freq_reg == `FREQ_PING_HALF && duty_reg == `DUTY_MAX)
    else $error("ping not at start point");
  chk_integral_bound: assert property (isc_reg <= 20'sh0EA60 && // see [RQ13]
    isc_reg >= -20'sh0EA60)
    else $error("integral above limit");
  chk_pid_bound: assert property (pid_reg <= 16'sh4E20 && pid_reg >= -16'sh4E20) // see [RQ10]
    else $error("loop output above limit");
  chk_freq_down: assert property (freq_step ##0 (pid_new > 0 && freq_reg > `FREQ_MIN_HALF)
    |=> freq_reg < $past(freq_reg)) // see [RQ3]
    else $error("frequency not lowered for more power");
  chk_duty_down: assert property (state_reg == power_drive_pkg::ST_REG && step && duty_ctl &&
    pid_new < 0 && duty_reg > `DUTY_MIN |=> duty_reg < $past(duty_reg)) // see [RQ11]
    else $error("duty not lowered for less power");
  chk_band_top: assert property (freq_reg >= `FREQ_B180_HALF |-> // see [RQ12]
    scale_half == `SCALE_B180)
    else $error("wrong top band scale");
  chk_ping_hold: assert property (state_reg == power_drive_pkg::ST_PING && !step
    && ctrl_reg[`CTRL_EN_BIT] |=> $stable(freq_reg) && $stable(duty_reg)) // see [RQ7]
    else $error("ping point moved");
  chk_write_answer: assert property (aw_full_reg && w_full_reg && !bvalid_reg |=> bvalid_reg)
    else $error("write not answered");
endmodule : inductive_power_drive_pid

// ### pkg/bridge_if.sv
`timescale 1ns/1ns
interface bridge_if;
  power_drive_pkg::freq_type freq;
  power_drive_pkg::duty_type duty;
  logic                      run;
  logic                      leg_a;
  logic                      leg_b;
  modport ctrl (output freq, duty, run, input leg_a, leg_b);
  modport gen (input freq, duty, run, output leg_a, leg_b);
endinterface : bridge_if

// ### pkg/power_drive_map.svh
`ifndef POWER_DRIVE_MAP_SVH
`define POWER_DRIVE_MAP_SVH
// ----------------------------------------
// clock and loop timing
// ----------------------------------------
`define CLK_MHZ        100
`define STEP_US        1000
// ----------------------------------------
// frequency points in 0.5 Hz units
// ----------------------------------------
`define FREQ_MIN_HALF  19'h35B60
`define FREQ_MAX_HALF  19'h64190
`define FREQ_PING_HALF 19'h55730
`define FREQ_B140_HALF 19'h445C0
`define FREQ_B160_HALF 19'h4E200
`define FREQ_B180_HALF 19'h57E40
// band scaling factors in 0.5 Hz units
`define SCALE_B110     4'h3
`define SCALE_B140     4'h4
`define SCALE_B160     4'h6
`define SCALE_B180     4'hA
// ----------------------------------------
// duty cycle in 0.01 % units
// ----------------------------------------
`define DUTY_MAX       14'h1388
`define DUTY_MIN       14'h03E8
// ----------------------------------------
// loop constants (integral kept times 20)
// ----------------------------------------
`define PROP_GAIN      24'sh00000A
`define INT_LIMIT      24'sh00EA60
`define PID_LIMIT      24'sh004E20
`define INT_DIV_MUL    14'sh0CCD
// ----------------------------------------
// oscillator constants
// ----------------------------------------
`define NCO_INC_MUL    21'h15798F
`define DUTY_THR_MUL   19'h68DB8
`define PHASE_HALF     32'h80000000
// ----------------------------------------
// register map
// ----------------------------------------
`define REG_CTRL       8'h00
`define REG_TARGET     8'h04
`define REG_STATUS     8'h08
`define REG_FREQ       8'h0C
`define REG_DUTY       8'h10
`define REG_CURRENT    8'h14
`define REG_PID        8'h18
`define CTRL_EN_BIT    0
`define CTRL_DUTY_BIT  1
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ### pkg/power_drive_pkg.sv
package power_drive_pkg;
  typedef enum logic [1:0] {
    ST_OFF  = 2'h0,
    ST_PING = 2'h1,
    ST_REG  = 2'h3
  } drive_state_type;
  typedef logic [18:0] freq_type;
  typedef logic [13:0] duty_type;
endpackage : power_drive_pkg
